// >>> hdl/sdrbw_pkg.sv
// Shared constants and types for the DRAM burst link
package sdrbw_pkg;
   localparam int DATA_W  = 32;
   localparam int COL_W   = 9;
   localparam int BANK_W  = 2;
   localparam int NBANKS  = 4;
   localparam int MASK_W  = 4;
   localparam int MODE_W  = 12;
   localparam int ROW_W   = 12;
   // Mode register fields
   localparam int MODE_BL_LSB   = 0;
   localparam int MODE_ORDER    = 3;
   localparam int MODE_LAT_LSB  = 4;
   localparam int MODE_WBM      = 9;
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [2:0] LAT_2   = 3'h2;
   localparam logic [2:0] LAT_3   = 3'h3;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h022;
   localparam logic [COL_W-1:0] COL_LAST = 9'h1FF;
   localparam int DEPTH = NBANKS * (1 << COL_W);
   // Timing in ns and in cycles at a 10 ns clock
   localparam int CLK_NS        = 10;
   localparam int PRE_REC_NS    = 18;
   localparam int WR_REC_NS     = 12;
   localparam int PRE_REC_CYC   = (PRE_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_REC_CYC    = (WR_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int MASK_LEAD_CYC = 3;
   localparam int MASK_OUT_LAT  = 2;
   // Commands on the link
   typedef enum logic [2:0] {
      SDRBW_NOP, SDRBW_READ, SDRBW_WRITE, SDRBW_PRE, SDRBW_STOP
   } sdrbw_cmd_e;
endpackage

// >>> hdl/sdrbw_if.sv
// Link between controller and DRAM, data lines resolved from enables
interface sdrbw_if;
   import sdrbw_pkg::*;
   sdrbw_cmd_e              cmd;
   logic [BANK_W-1:0]       bank;
   logic [COL_W-1:0]        col;
   logic                    auto_pre;
   logic [MASK_W-1:0]       mask;
   logic [DATA_W-1:0]       ctl_dq_o;
   logic                    ctl_dq_oe;
   logic [DATA_W-1:0]       mem_dq_o;
   logic                    mem_dq_oe;
   logic [DATA_W-1:0]       dq;
   assign dq = ctl_dq_oe ? ctl_dq_o : (mem_dq_oe ? mem_dq_o : '0);
   modport ctl (output cmd, bank, col, auto_pre, mask, ctl_dq_o, ctl_dq_oe, input dq);
   modport mem (input cmd, bank, col, auto_pre, mask, dq, output mem_dq_o, mem_dq_oe);
endinterface

// >>> hdl/sdrbw_seq.sv
// Burst column sequencer: next column for sequential, interleaved or page bursts
module sdrbw_seq
   import sdrbw_pkg::*;
(
   input  wire logic [COL_W-1:0] i_start,
   input  wire logic [COL_W-1:0] i_idx,
   input  wire logic [2:0]       i_bl,
   input  wire logic             i_order,
   output logic      [COL_W-1:0] o_col
);
   logic [COL_W-1:0] blk_mask;
   // Wrap inside the burst block; full page wraps at the page end
   always_comb begin
      unique case (i_bl)
         BL_2:    blk_mask = 9'h001;
         BL_4:    blk_mask = 9'h003;
         BL_8:    blk_mask = 9'h007;
         BL_PAGE: blk_mask = 9'h1FF;
         default: blk_mask = 9'h000;
      endcase
      if (i_order && i_bl != BL_PAGE)
         o_col = (i_start & ~blk_mask) | ((i_start ^ i_idx) & blk_mask);
      else
         o_col = (i_start & ~blk_mask) | ((i_start + i_idx) & blk_mask);
   end
endmodule

// >>> hdl/sdrbw_mem.sv
// DRAM end: read and write bursts, truncation, masking and auto precharge
//
// Added by the designer: the placing of the registers.
module sdrbw_mem
   import sdrbw_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic [MODE_W-1:0] i_mode,
   sdrbw_if.mem                   link,
   output logic [NBANKS-1:0]      o_row_open,
   output logic                   o_bad_write
);
   typedef enum logic [1:0] {SDRBW_IDLE, SDRBW_RD, SDRBW_WR} sdrbw_st_e;
   typedef struct packed {
      sdrbw_st_e              st;
      logic [BANK_W-1:0]      bank;
      logic [COL_W-1:0]       start;
      logic [COL_W-1:0]       idx;
      logic                   ap;
      logic [2:0]             bl;
      logic [2:0]             v;
      logic [2:0][COL_W+BANK_W-1:0] addr;
      // Mask seen at the last edge, blanks the word due one edge after it
      logic [MASK_W-1:0]      mk;
      logic                   oe;
      logic [DATA_W-1:0]      dout;
      logic                   mask_prev;
      logic [NBANKS-1:0]      open;
      logic                   bad;
   } sdrbw_mem_s;

   sdrbw_mem_s r;
   sdrbw_mem_s n;
   logic [COL_W+BANK_W-1:0] rd_addr;
   wire  logic [DATA_W-1:0] rd_lanes;
   logic [COL_W-1:0]  cur_col;
   logic [COL_W-1:0]  bl_last;
   logic [2:0]        bl;
   logic [1:0]        lat_tap;
   logic              rd_word;
   logic              wr_en;
   logic [COL_W+BANK_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [MASK_W-1:0] wr_mask;

   // Burst length as programmed
   assign bl = i_mode[MODE_BL_LSB +: 3];
   // Read latency selects the pipeline tap: word 0 enters stage 0 on the command
   // edge and the output register adds one more, so stage latency-2 feeds it
   assign lat_tap = (i_mode[MODE_LAT_LSB +: 3] == LAT_3) ? 2'h1 : 2'h0;
   assign rd_addr = r.addr[lat_tap];

   sdrbw_seq u_seq (
      .i_start (r.start),
      .i_idx   (r.idx),
      .i_bl    (r.bl),
      .i_order (i_mode[MODE_ORDER]),
      .o_col   (cur_col)
   );

   // Last burst index for the active length
   always_comb begin
      unique case (r.bl)
         BL_2:    bl_last = 9'h001;
         BL_4:    bl_last = 9'h003;
         BL_8:    bl_last = 9'h007;
         default: bl_last = 9'h000;
      endcase
   end

   // Burst engine
   always_comb begin
      n          = r;
      wr_en      = 1'b0;
      wr_addr    = {r.bank, cur_col};
      wr_data    = link.dq;
      wr_mask    = link.mask;
      rd_word    = 1'b0;
      o_bad_write = r.bad;
      n.mask_prev = |link.mask;
      n.bad      = 1'b0;
      n.v        = {r.v[1:0], 1'b0};
      n.addr     = {r.addr[1:0], {r.bank, cur_col}};
      n.mk       = link.mask;
      // Step the active burst
      if (r.st != SDRBW_IDLE) begin
         if (r.st == SDRBW_RD) begin
            rd_word = 1'b1;
         end else begin
            wr_en = 1'b1;
         end
         n.idx = r.idx + 9'h001;
         // Fixed bursts stop on their last index; a page burst wraps on
         if (r.bl != BL_PAGE && r.idx == bl_last) begin
            n.st = SDRBW_IDLE;
            if (r.ap) begin
               n.open[r.bank] = 1'b0;
            end
         end
      end
      n.v[0] = rd_word;
      // New read, write or stop truncates whatever runs; a precharge only if it hits the burst's bank
      unique case (link.cmd)
         SDRBW_READ: begin
            // First word enters the read pipe on the command edge, so the
            // sequencer resumes at the second burst index
            wr_en     = 1'b0;
            n.st      = (bl == BL_1) ? SDRBW_IDLE : SDRBW_RD;
            n.bank    = link.bank;
            n.start   = link.col;
            n.idx     = 9'h001;
            n.ap      = link.auto_pre;
            n.bl      = bl;
            n.v[0]    = 1'b1;
            n.addr[0] = {link.bank, link.col};
            n.open[link.bank] = ~(link.auto_pre && bl == BL_1);
         end
         SDRBW_WRITE: begin
            // First word taken on the command edge
            wr_en   = 1'b1;
            wr_addr = {link.bank, link.col};
            n.st    = (bl == BL_1 || i_mode[MODE_WBM]) ? SDRBW_IDLE : SDRBW_WR;
            n.bank  = link.bank;
            n.start = link.col;
            n.idx   = 9'h001;
            n.ap    = link.auto_pre;
            n.bl    = i_mode[MODE_WBM] ? BL_1 : bl;
            n.open[link.bank] = ~(link.auto_pre && n.st == SDRBW_IDLE);
            // A write cuts any read still in the pipe; flag it unless mask was up
            n.v     = '0;
            n.bad   = (r.st == SDRBW_RD || r.v != '0) && !r.mask_prev;
         end
         SDRBW_PRE: begin
            wr_en = 1'b0;
            if (link.bank == r.bank) begin
               n.st   = SDRBW_IDLE;
               n.v[0] = 1'b0;
            end
            n.open[link.bank] = 1'b0;
         end
         SDRBW_STOP: begin
            wr_en = 1'b0;
            n.st   = SDRBW_IDLE;
            n.v[0] = 1'b0;
         end
         default: ;
      endcase
      // Output stage: word driven at the selected latency
      n.oe   = r.v[lat_tap] && link.cmd != SDRBW_WRITE;
      n.dout = rd_lanes;
      // Mask taken at the last edge blanks the word valid one edge after this
      if (r.mk != '0) begin
         n.oe = 1'b0;
      end
      if (!r.v[lat_tap]) begin
         n.oe = 1'b0;
      end
   end

   // Storage with byte lanes; each lane owns its array so one process writes it
   genvar g;
   generate
      for (g = 0; g < MASK_W; g++) begin : g_lane
         logic [7:0] lane_mem [DEPTH];
         always_ff @(posedge i_core_clk) begin
            if (wr_en && !wr_mask[g]) begin
               lane_mem[wr_addr] <= wr_data[8*g +: 8];
            end
         end
         assign rd_lanes[8*g +: 8] = lane_mem[rd_addr];
      end
   endgenerate

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= '{st: SDRBW_IDLE, bl: BL_1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign link.mem_dq_o  = r.dout;
   assign link.mem_dq_oe = r.oe;
   assign o_row_open     = r.open;
endmodule

// >>> hdl/sdrbw_ctl.sv
// Controller end: issues one access per request, drives write data and masks
module sdrbw_ctl
   import sdrbw_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_req,
   input  wire sdrbw_cmd_e        i_cmd,
   input  wire logic [BANK_W-1:0] i_bank,
   input  wire logic [COL_W-1:0]  i_col,
   input  wire logic              i_auto_pre,
   input  wire logic [MASK_W-1:0] i_mask,
   input  wire logic [DATA_W-1:0] i_wdata,
   sdrbw_if.ctl                   link,
   output logic                   o_busy,
   output logic                   o_refused,
   output logic [DATA_W-1:0]      o_rdata
);
   typedef struct packed {
      sdrbw_cmd_e              cmd;
      logic [BANK_W-1:0]       bank;
      logic [COL_W-1:0]        col;
      logic                    ap;
      logic [MASK_W-1:0]       mask;
      logic [DATA_W-1:0]       wd;
      logic                    oe;
      logic [NBANKS-1:0]       ap_busy;
      logic [NBANKS-1:0][2:0]  rec;
      logic                    refused;
      logic [DATA_W-1:0]       rd;
   } sdrbw_ctl_s;
   sdrbw_ctl_s r;
   sdrbw_ctl_s n;

   // Issue, refuse or recover
   always_comb begin
      n         = r;
      n.cmd     = SDRBW_NOP;
      n.oe      = 1'b0;
      n.refused = 1'b0;
      n.mask    = i_mask;
      n.rd      = link.dq;
      for (int b = 0; b < NBANKS; b++) begin
         if (r.rec[b] != 3'h0) begin
            n.rec[b] = r.rec[b] - 3'h1;
         end
      end
      if (i_req) begin
         if (r.rec[i_bank] != 3'h0 ||
             ((i_cmd == SDRBW_PRE || i_cmd == SDRBW_STOP) && r.ap_busy[i_bank])) begin
            n.refused = 1'b1;
         end else begin
            n.cmd  = i_cmd;
            n.bank = i_bank;
            n.col  = i_col;
            n.ap   = i_auto_pre;
            n.wd   = i_wdata;
            n.oe   = (i_cmd == SDRBW_WRITE);
            if (i_cmd == SDRBW_READ || i_cmd == SDRBW_WRITE) begin
               n.ap_busy[i_bank] = i_auto_pre;
            end
            if (i_cmd == SDRBW_PRE) begin
               n.rec[i_bank] = 3'(PRE_REC_CYC);
               n.mask        = '1;
            end
         end
      end else begin
         n.ap_busy = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= '{cmd: SDRBW_NOP, default: '0};
      end else begin
         r <= n;
      end
   end

   assign link.cmd       = r.cmd;
   assign link.bank      = r.bank;
   assign link.col       = r.col;
   assign link.auto_pre  = r.ap;
   assign link.mask      = r.mask;
   assign link.ctl_dq_o  = r.wd;
   assign link.ctl_dq_oe = r.oe;
   assign o_busy         = |r.rec;
   assign o_refused      = r.refused;
   assign o_rdata        = r.rd;
endmodule

// >>> bench/sdrbw_props.sv
// Assertions on the controller to DRAM burst link
module sdrbw_props
   import sdrbw_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic [MODE_W-1:0] i_mode,
   input  wire sdrbw_cmd_e        cmd,
   input  wire logic [BANK_W-1:0] bank,
   input  wire logic [MASK_W-1:0] mask,
   input  wire logic              ctl_dq_oe,
   input  wire logic              mem_dq_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // Shorthands for mode and command decode
   wire l2 = i_mode[MODE_LAT_LSB +: 3] == LAT_2;
   wire l3 = i_mode[MODE_LAT_LSB +: 3] == LAT_3;
   wire rd = cmd == SDRBW_READ && mask == 4'h0;
   wire wr = cmd == SDRBW_WRITE;
   a_no_contention: assert property (!(ctl_dq_oe && mem_dq_oe))
      else $error("both ends drive the data lines");
   a_read_lat_two: assert property ((rd && l2) ##1 !wr |=> mem_dq_oe)
      else $error("no read word two cycles after read");
   a_read_lat_three: assert property ((rd && l3) ##1 (!wr && mask == 4'h0) ##1 !wr |=> mem_dq_oe)
      else $error("no read word three cycles after read");
   a_burst_end_float: assert property ((rd && l2 && i_mode[2:0] == BL_4)
      ##1 (cmd == SDRBW_NOP && mask == 4'h0)[*5] |-> mem_dq_oe ##1 !mem_dq_oe)
      else $error("four word read did not end and float");
   a_stop_float: assert property ((cmd == SDRBW_STOP && l2) ##1 cmd == SDRBW_NOP |=> !mem_dq_oe)
      else $error("read still driving after burst stop");
   a_write_quiet: assert property (wr |=> !mem_dq_oe)
      else $error("device drives after write");
   a_write_drive: assert property (wr |-> ctl_dq_oe)
      else $error("write word not driven with command");
   a_pre_recovery: assert property (cmd == SDRBW_PRE |=> (cmd == SDRBW_NOP || bank != $past(bank)))
      else $error("command to bank in precharge recovery");
   a_chain_read: assert property ((rd && l2) ##1 rd ##1 !wr |-> mem_dq_oe ##1 mem_dq_oe)
      else $error("gap in chained read data");
   c_lat3: cover property (rd && l3);
   c_stop: cover property (cmd == SDRBW_STOP);
   c_wr_rd: cover property (wr ##1 cmd == SDRBW_READ);
endmodule

// >>> bench/testbench.sv
// Bench driving the controller end against the DRAM end over the link
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import sdrbw_pkg::*;
   localparam logic [DATA_W-1:0] W2 = 32'h1234_0002;
   localparam logic [DATA_W-1:0] WX = 32'h5A5A_0010;
   localparam logic [DATA_W-1:0] WY = 32'hC3C3_0020;
   logic              i_core_clk = 1'b0;
   logic              i_reset    = 1'b1;
   logic              i_req      = 1'b0;
   sdrbw_cmd_e        i_cmd      = SDRBW_NOP;
   logic [BANK_W-1:0] i_bank     = '0;
   logic [COL_W-1:0]  i_col      = '0;
   logic              i_auto_pre = 1'b0;
   logic [MASK_W-1:0] i_mask     = '0;
   logic [DATA_W-1:0] i_wdata    = '0;
   logic [MODE_W-1:0] i_mode     = MODE_RESET;
   logic              o_busy;
   logic              o_refused;
   logic              o_bad_write;
   logic [DATA_W-1:0] o_rdata;
   logic [NBANKS-1:0] o_row_open;
   logic [DATA_W-1:0] q[$];
   logic [DATA_W-1:0] p_dq     = '0;
   logic              p_oe     = 1'b0;
   logic              ref_seen = 1'b0;
   logic              bad_seen = 1'b0;
   int                n_fail     = 0;
   int                num_checks = 0;
   sdrbw_if link ();
   // Clock
   always #5 i_core_clk = ~i_core_clk;
   sdrbw_ctl sdrbw_ctl_inst (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_req(i_req),
      .i_cmd(i_cmd), .i_bank(i_bank), .i_col(i_col), .i_auto_pre(i_auto_pre), .i_mask(i_mask),
      .i_wdata(i_wdata), .link(link), .o_busy(o_busy), .o_refused(o_refused), .o_rdata(o_rdata));
   sdrbw_mem sdrbw_mem_inst (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_mode(i_mode),
      .link(link), .o_row_open(o_row_open), .o_bad_write(o_bad_write));
   sdrbw_props sdrbw_props_inst (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_mode(i_mode),
      .cmd(link.cmd), .bank(link.bank), .mask(link.mask), .ctl_dq_oe(link.ctl_dq_oe),
      .mem_dq_oe(link.mem_dq_oe));
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Collect read words, watch refusals and the delayed read register
   always @(negedge i_core_clk) begin
      if (p_oe) chk(o_rdata, p_dq);
      if (link.mem_dq_oe === 1'b1) q.push_back(link.dq);
      if (o_refused === 1'b1) ref_seen = 1'b1;
      if (o_bad_write === 1'b1) bad_seen = 1'b1;
      p_oe = link.mem_dq_oe;
      p_dq = link.dq;
   end
   function automatic logic [DATA_W-1:0] fv(input logic [COL_W-1:0] c);
      return 32'hA500_0000 | 32'(c);
   endfunction
   task automatic set_mode(input logic [2:0] bl, input logic o, input logic [2:0] lat,
                           input logic w);
      i_mode <= {2'h0, w, 2'h0, lat, o, bl};
      @(posedge i_core_clk);
   endtask
   task automatic issue(input sdrbw_cmd_e c, input logic [COL_W-1:0] col,
         input logic [DATA_W-1:0] d = '0, input logic [MASK_W-1:0] m = '0,
         input logic [BANK_W-1:0] b = '0, input logic ap = 1'b0);
      i_req      <= 1'b1;
      i_cmd      <= c;
      i_col      <= col;
      i_wdata    <= d;
      i_mask     <= m;
      i_bank     <= b;
      i_auto_pre <= ap;
      @(posedge i_core_clk);
   endtask
   task automatic idle(input int n);
      i_req <= 1'b0;
      repeat (n) @(posedge i_core_clk);
   endtask
   // One read, optionally cut by a second command after a gap
   task automatic rd_chk(input logic [COL_W-1:0] c, input logic [DATA_W-1:0] e[$],
         input sdrbw_cmd_e cut = SDRBW_NOP, input int gap = 0, input logic [COL_W-1:0] c2 = '0);
      q = {};
      ref_seen = 1'b0;
      issue(SDRBW_READ, c);
      if (gap > 0) idle(gap);
      if (cut != SDRBW_NOP) issue(cut, c2);
      idle(12);
      chk(32'(q.size()), 32'(e.size()));
      foreach (e[i]) chk(q[i], e[i]);
      chk(32'(ref_seen), 32'h0);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (5000) @(posedge i_core_clk);
      n_fail++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge i_core_clk);
      i_reset <= 1'b0;
      set_mode(BL_4, 1'b0, LAT_2, 1'b1);
      for (int c = 0; c < 64; c++) issue(SDRBW_WRITE, COL_W'(c), fv(COL_W'(c)));
      issue(SDRBW_WRITE, COL_LAST - 9'h001, fv(COL_LAST - 9'h001));
      issue(SDRBW_WRITE, COL_LAST, fv(COL_LAST));
      issue(SDRBW_WRITE, 9'h002, 32'h1234_5678, 4'h3);
      idle(4);
      chk(32'(o_row_open), 32'h1);
      set_mode(BL_4, 1'b0, LAT_2, 1'b0);
      rd_chk(9'h001, {fv(9'h001), W2, fv(9'h003), fv(9'h000)});
      set_mode(BL_4, 1'b1, LAT_2, 1'b0);
      rd_chk(9'h001, {fv(9'h001), fv(9'h000), fv(9'h003), W2});
      set_mode(BL_8, 1'b1, LAT_2, 1'b0);
      rd_chk(9'h005, {fv(9'h005), fv(9'h004), fv(9'h007), fv(9'h006),
                      fv(9'h001), fv(9'h000), fv(9'h003), W2});
      set_mode(BL_4, 1'b0, LAT_3, 1'b0);
      rd_chk(9'h006, {fv(9'h006), fv(9'h007), fv(9'h004), fv(9'h005)});
      $display("test order and latency done");
      set_mode(BL_4, 1'b0, LAT_2, 1'b0);
      rd_chk(9'h000, {fv(9'h000), fv(9'h004), fv(9'h005), fv(9'h006), fv(9'h007)},
             SDRBW_READ, 0, 9'h004);
      issue(SDRBW_WRITE, 9'h010, WX);
      idle(6);
      rd_chk(9'h010, {WX, 32'h0, 32'h0, 32'h0});
      rd_chk(9'h014, {fv(9'h014), fv(9'h015), fv(9'h016), fv(9'h017)});
      issue(SDRBW_WRITE, 9'h030, WY);
      issue(SDRBW_READ, 9'h034);
      idle(10);
      rd_chk(9'h030, {WY, fv(9'h031), fv(9'h032), fv(9'h033)});
      $display("test write bursts done");
      set_mode(BL_PAGE, 1'b0, LAT_2, 1'b0);
      issue(SDRBW_WRITE, 9'h020, WY);
      issue(SDRBW_STOP, 9'h020);
      idle(4);
      rd_chk(COL_LAST - 9'h001, {fv(COL_LAST - 9'h001), fv(COL_LAST), fv(9'h000), fv(9'h001)},
             SDRBW_STOP, 3);
      set_mode(BL_4, 1'b0, LAT_2, 1'b0);
      rd_chk(9'h020, {WY, fv(9'h021), fv(9'h022), fv(9'h023)});
      rd_chk(9'h000, {fv(9'h000), fv(9'h001)}, SDRBW_PRE, 1);
      $display("test truncation done");
      ref_seen = 1'b0;
      issue(SDRBW_PRE, 9'h000, '0, '0, 2'h2);
      issue(SDRBW_READ, 9'h000, '0, '0, 2'h2);
      chk(32'(o_busy), 32'h1);
      idle(4);
      chk(32'(ref_seen), 32'h1);
      chk(32'(o_busy), 32'h0);
      ref_seen = 1'b0;
      issue(SDRBW_READ, 9'h000, '0, '0, 2'h1, 1'b1);
      issue(SDRBW_STOP, 9'h000, '0, '0, 2'h1);
      idle(8);
      chk(32'(ref_seen), 32'h1);
      chk(32'(o_row_open), 32'h0);
      $display("test refusals done");
      // Read cut by a write: masked lead-in is quiet, unmasked one is flagged
      q = {};
      bad_seen = 1'b0;
      issue(SDRBW_READ, 9'h008, '0, 4'hF);
      idle(1);
      issue(SDRBW_WRITE, 9'h040, WX);
      idle(6);
      chk(32'(q.size()), 32'h0);
      chk(32'(bad_seen), 32'h0);
      issue(SDRBW_READ, 9'h008);
      issue(SDRBW_WRITE, 9'h044, WX);
      idle(6);
      chk(32'(bad_seen), 32'h1);
      $display("test read to write turnaround done");
      report_and_stop();
   end
endmodule
